// >>> rtl/etm_chb_consts.svh
// constants for the enhanced timer channel-b block
`ifndef ETM_CHB_CONSTS_SVH
`define ETM_CHB_CONSTS_SVH

// register indices (address port is 4 bits)
`define REG_CTRL_A 4'h0
`define REG_CTRL_B 4'h1
`define REG_CNT_LO 4'h2
`define REG_CNT_HI 4'h3
`define REG_CMPA_LO 4'h4
`define REG_CMPA_HI 4'h5
`define REG_CMPB_LO 4'h6
`define REG_CMPB_HI 4'h7
`define REG_TIMER_ON 4'h8
// field positions in channel-b control
`define F_MODE_HI 7
`define F_MODE_LO 6
`define F_FUNC_HI 5
`define F_FUNC_LO 4
`define F_INIT 3
`define F_INV 2
`define F_ALIGN_HI 1
`define F_ALIGN_LO 0
`define CTRL_RESET 8'h00
`define CNT_ZERO 10'h000
`define CNT_MAX 10'h3FF
`define HI_PAD 6'h00
`define RD_ZERO 8'h00
// output function, pwm, capture edge and alignment codes
`define FN_NONE 2'h0
`define FN_LOW 2'h1
`define FN_HIGH 2'h2
`define FN_TOGGLE 2'h3
`define PW_INACTIVE 2'h0
`define PW_ACTIVE 2'h1
`define PW_PWM 2'h2
`define PW_PULSE 2'h3
`define CAP_RISE 2'h0
`define CAP_FALL 2'h1
`define CAP_BOTH 2'h2
`define AL_EDGE 2'h0
`define AL_UP 2'h1
`define AL_DOWN 2'h2
`define AL_BOTH 2'h3
`endif

// >>> rtl/etm_chb_pkg.sv
// types for the enhanced timer channel-b block
package etm_chb_pkg;
    typedef enum logic [1:0] {
        MODE_COMPARE = 2'b00,
        MODE_CAPTURE = 2'b01,
        MODE_PWM = 2'b10,
        MODE_TIMER = 2'b11
    } chan_mode_t;

    typedef struct packed {
        chan_mode_t chan_b_mode_sel;
        logic [1:0] chan_b_out_func;
        logic chan_b_init_level;
        logic chan_b_invert;
        logic [1:0] pwm_align_sel;
    } chan_b_ctrl_t;

    typedef struct packed {
        logic [3:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } reg_req_t;
endpackage

// >>> rtl/etm_chb.sv
// enhanced timer compare/capture channel b with counter and register port
`timescale 1ns/100ps
`include "etm_chb_consts.svh"
module etm_chb
    import etm_chb_pkg::*;
(
    input wire logic i_clock,
    input wire logic i_rst,
    input wire logic i_clk_en,
    input wire logic i_count_tick,
    input wire reg_req_t i_req,
    input wire logic [2:0] i_chan_b_pin_in,
    output logic [7:0] o_rdata,
    output logic [2:0] o_chan_b_pin_out,
    output logic [2:0] o_chan_b_pin_oe_n,
    output logic o_chan_b_match_flag,
    output logic o_capture_strobe
);

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    logic [7:0] ctrl_a_q;
    chan_b_ctrl_t ctrl_b_q;
    logic timer_on_q;
    logic timer_on_prev_q;
    logic [9:0] compare_value_a_q;
    logic [9:0] compare_value_b_q;
    logic [9:0] count_q;
    logic count_down_q;
    logic out_level_q;
    logic pulse_done_q;
    logic [2:0] pin_prev_q;
    logic [9:0] capture_q;
    logic on_rise;
    logic match_b;
    logic match_a;
    logic at_period;
    logic centre;
    logic [1:0] func;
    logic level_d;
    logic pin_d;
    logic cap_evt;

    assign func = ctrl_b_q.chan_b_out_func;
    assign on_rise = timer_on_q & ~timer_on_prev_q;
    assign centre = (ctrl_b_q.pwm_align_sel != `AL_EDGE);
    assign match_a = (count_q == compare_value_a_q);
    // compare a sets the period: a zero value lets the counter run to its maximum
    assign at_period = (compare_value_a_q == `CNT_ZERO) ? (count_q == `CNT_MAX) : match_a;

    // software writes; channel-a control is stored so its mode can be read back
    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            ctrl_a_q <= `CTRL_RESET;
            ctrl_b_q <= chan_b_ctrl_t'(`CTRL_RESET);
            timer_on_q <= 1'b0;
            compare_value_a_q <= `CNT_ZERO;
            compare_value_b_q <= `CNT_ZERO;
        end else if (i_clk_en && i_req.wr) begin
            if (i_req.addr == `REG_CTRL_A) begin
                ctrl_a_q <= i_req.wdata;
            end else if (i_req.addr == `REG_CTRL_B) begin
                ctrl_b_q <= chan_b_ctrl_t'(i_req.wdata);
            end else if (i_req.addr == `REG_CMPA_LO) begin
                compare_value_a_q[7:0] <= i_req.wdata;
            end else if (i_req.addr == `REG_CMPA_HI) begin
                compare_value_a_q[9:8] <= i_req.wdata[1:0];
            end else if (i_req.addr == `REG_CMPB_LO) begin
                compare_value_b_q[7:0] <= i_req.wdata;
            end else if (i_req.addr == `REG_CMPB_HI) begin
                compare_value_b_q[9:8] <= i_req.wdata[1:0];
            end else if (i_req.addr == `REG_TIMER_ON) begin
                timer_on_q <= i_req.wdata[0];
            end
        end
    end

    // edge memory of the on bit
    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            timer_on_prev_q <= 1'b0;
        end else if (i_clk_en) begin
            timer_on_prev_q <= timer_on_q;
        end
    end

    // ------------------------------------------------------------
    // counter
    // ------------------------------------------------------------
    // centre alignment counts up to the period then back down
    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            count_q <= `CNT_ZERO;
            count_down_q <= 1'b0;
        end else if (i_clk_en) begin
            if (on_rise) begin
                count_q <= `CNT_ZERO;
                count_down_q <= 1'b0;
            end else if (timer_on_q && i_count_tick) begin
                if (centre && count_down_q) begin
                    if (count_q == `CNT_ZERO) begin
                        count_down_q <= 1'b0;
                        count_q <= count_q + 10'h001;
                    end else begin
                        count_q <= count_q - 10'h001;
                    end
                end else if (at_period) begin
                    if (centre) begin
                        count_down_q <= 1'b1;
                        count_q <= count_q - 10'h001;
                    end else begin
                        count_q <= `CNT_ZERO;
                    end
                end else begin
                    count_q <= count_q + 10'h001;
                end
            end
        end
    end

    // ------------------------------------------------------------
    // channel b compare
    // ------------------------------------------------------------
    // match qualified by direction in pwm mode when aligned to up or down counting
    always_comb begin
        match_b = timer_on_q && i_count_tick && (count_q == compare_value_b_q);
        if (centre && ctrl_b_q.chan_b_mode_sel == MODE_PWM) begin
            if (ctrl_b_q.pwm_align_sel == `AL_UP) begin
                match_b = match_b && !count_down_q;
            end else if (ctrl_b_q.pwm_align_sel == `AL_DOWN) begin
                match_b = match_b && count_down_q;
            end
        end
    end

    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            o_chan_b_match_flag <= 1'b0;
        end else if (i_clk_en) begin
            o_chan_b_match_flag <= match_b && ctrl_b_q.chan_b_mode_sel != MODE_CAPTURE;
        end
    end

    // output level before polarity; the b match and a timer start move it in compare mode
    always_comb begin
        level_d = out_level_q;
        // only compare mode restores the initial level; pwm recomputes its level every cycle
        if (on_rise && ctrl_b_q.chan_b_mode_sel == MODE_COMPARE) begin
            level_d = ctrl_b_q.chan_b_init_level;
        end else if (ctrl_b_q.chan_b_mode_sel == MODE_COMPARE && match_b) begin
            // a requested level equal to the current one leaves the pin put
            case (func)
                `FN_LOW: level_d = 1'b0;
                `FN_HIGH: level_d = 1'b1;
                `FN_TOGGLE: level_d = ~out_level_q;
                default: level_d = out_level_q;
            endcase
        end else if (ctrl_b_q.chan_b_mode_sel == MODE_PWM) begin
            // pwm level is the active flag; init level picks the active sense later
            case (func)
                `PW_INACTIVE: level_d = 1'b0;
                `PW_ACTIVE: level_d = 1'b1;
                `PW_PWM: level_d = (compare_value_b_q > count_q) || at_period && !centre
                    && (compare_value_b_q > compare_value_a_q) || (compare_value_a_q == `CNT_ZERO
                    && compare_value_b_q == `CNT_MAX);
                default: level_d = !pulse_done_q && (compare_value_b_q > count_q) && timer_on_q;
            endcase
        end
    end

    // single pulse ends at the first b match and rearms on a fresh start
    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            out_level_q <= 1'b0;
            pulse_done_q <= 1'b0;
        end else if (i_clk_en) begin
            out_level_q <= level_d;
            if (on_rise) begin
                pulse_done_q <= 1'b0;
            end else if (match_b && func == `PW_PULSE) begin
                pulse_done_q <= 1'b1;
            end
        end
    end

    // pin value: compare mode shows the level; pwm applies the active sense; then polarity
    always_comb begin
        if (ctrl_b_q.chan_b_mode_sel == MODE_PWM) begin
            pin_d = level_d ? ctrl_b_q.chan_b_init_level : ~ctrl_b_q.chan_b_init_level;
        end else begin
            pin_d = level_d;
        end
        pin_d = pin_d ^ ctrl_b_q.chan_b_invert;
    end

    // ------------------------------------------------------------
    // pins and capture
    // ------------------------------------------------------------
    // timer/counter and capture modes release the pins; init and invert then do nothing
    genvar g;
    generate
        for (g = 0; g < 3; g = g + 1) begin : g_pin
            always_ff @(posedge i_clock) begin
                if (i_rst) begin
                    o_chan_b_pin_out[g] <= 1'b0;
                    o_chan_b_pin_oe_n[g] <= 1'b1;
                    pin_prev_q[g] <= 1'b0;
                end else if (i_clk_en) begin
                    o_chan_b_pin_out[g] <= pin_d;
                    o_chan_b_pin_oe_n[g] <= ctrl_b_q.chan_b_mode_sel == MODE_TIMER
                        || ctrl_b_q.chan_b_mode_sel == MODE_CAPTURE;
                    pin_prev_q[g] <= i_chan_b_pin_in[g];
                end
            end
        end
    endgenerate

    // capture watches pin 0 edges
    always_comb begin
        case (func)
            `CAP_RISE: cap_evt = i_chan_b_pin_in[0] && !pin_prev_q[0];
            `CAP_FALL: cap_evt = !i_chan_b_pin_in[0] && pin_prev_q[0];
            `CAP_BOTH: cap_evt = i_chan_b_pin_in[0] != pin_prev_q[0];
            default: cap_evt = 1'b0;
        endcase
        cap_evt = cap_evt && ctrl_b_q.chan_b_mode_sel == MODE_CAPTURE && timer_on_q;
    end

    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            capture_q <= `CNT_ZERO;
            o_capture_strobe <= 1'b0;
        end else if (i_clk_en) begin
            o_capture_strobe <= cap_evt;
            if (cap_evt) begin
                capture_q <= count_q;
            end
        end
    end

    // ------------------------------------------------------------
    // read port
    // ------------------------------------------------------------
    // capture mode reports the captured count in the counter registers
    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            o_rdata <= `RD_ZERO;
        end else if (i_clk_en) begin
            if (!i_req.rd) begin
                o_rdata <= `RD_ZERO;
            end else if (i_req.addr == `REG_CTRL_A) begin
                o_rdata <= ctrl_a_q;
            end else if (i_req.addr == `REG_CTRL_B) begin
                o_rdata <= ctrl_b_q;
            end else if (i_req.addr == `REG_CNT_LO) begin
                o_rdata <= (ctrl_b_q.chan_b_mode_sel == MODE_CAPTURE) ? capture_q[7:0] : count_q[7:0];
            end else if (i_req.addr == `REG_CNT_HI) begin
                o_rdata <= {`HI_PAD, (ctrl_b_q.chan_b_mode_sel == MODE_CAPTURE) ? capture_q[9:8]
                    : count_q[9:8]};
            end else if (i_req.addr == `REG_CMPA_LO) begin
                o_rdata <= compare_value_a_q[7:0];
            end else if (i_req.addr == `REG_CMPA_HI) begin
                o_rdata <= {`HI_PAD, compare_value_a_q[9:8]};
            end else if (i_req.addr == `REG_CMPB_LO) begin
                o_rdata <= compare_value_b_q[7:0];
            end else if (i_req.addr == `REG_CMPB_HI) begin
                o_rdata <= {`HI_PAD, compare_value_b_q[9:8]};
            end else if (i_req.addr == `REG_TIMER_ON) begin
                o_rdata <= {7'h00, timer_on_q};
            end else begin
                o_rdata <= `RD_ZERO;
            end
        end
    end
endmodule

// >>> bench/etm_chb_properties.sv
// assertions on the ports of the channel-b timer block
`timescale 1ns/100ps
module etm_chb_properties
    import etm_chb_pkg::*;
(
    input wire logic i_clock,
    input wire logic i_rst,
    input wire logic i_clk_en,
    input wire logic i_count_tick,
    input wire reg_req_t i_req,
    input wire logic [2:0] i_chan_b_pin_in,
    input wire logic [7:0] o_rdata,
    input wire logic [2:0] o_chan_b_pin_out,
    input wire logic [2:0] o_chan_b_pin_oe_n,
    input wire logic o_chan_b_match_flag,
    input wire logic o_capture_strobe
);
    // ----------------------------------------
    // shadow of the channel-b control register
    // ----------------------------------------
    chan_b_ctrl_t ctrl_q;
    logic [1:0] quiet_q;
    logic calm;
    logic cm;
    logic [1:0] fn;
    logic [2:0] pins;
    assign calm = quiet_q == 2'h3;
    assign cm = ctrl_q.chan_b_mode_sel == MODE_COMPARE;
    assign fn = ctrl_q.chan_b_out_func;
    assign pins = o_chan_b_pin_out;
    // pins may move for a few cycles after a config write, so checks wait
    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            ctrl_q <= chan_b_ctrl_t'(8'h00);
            quiet_q <= 2'h0;
        end else begin
            if (i_clk_en && i_req.wr && i_req.addr == 4'h1) begin
                ctrl_q <= chan_b_ctrl_t'(i_req.wdata);
            end
            if (!i_clk_en || (i_req.wr && i_req.addr inside {4'h1, 4'h8})) begin
                quiet_q <= 2'h0;
            end else if (!calm) begin
                quiet_q <= quiet_q + 2'h1;
            end
        end
    end
    default clocking @(posedge i_clock); endclocking
    default disable iff (i_rst);
    chk_high_pad: assert property (i_clk_en && i_req.rd && i_req.addr inside {4'h3, 4'h5, 4'h7}
        |=> o_rdata[7:2] == 6'h00) else $error("high pad set");
    chk_pins_same: assert property (pins == {3{pins[0]}}) else $error("pins differ");
    chk_oe_off: assert property (calm && ctrl_q.chan_b_mode_sel inside {MODE_CAPTURE, MODE_TIMER}
        |-> o_chan_b_pin_oe_n == 3'h7) else $error("pins driven");
    chk_pin_hold: assert property (calm && cm && !o_chan_b_match_flag |-> $stable(pins))
        else $error("pin moved");
    chk_func_none: assert property (calm && cm && fn == 2'h0 |-> $stable(pins))
        else $error("pin moved");
    chk_set_level: assert property (calm && cm && o_chan_b_match_flag && fn inside {2'h1, 2'h2}
        |-> pins == {3{fn[1] ^ ctrl_q.chan_b_invert}}) else $error("bad level");
    chk_toggle_pin: assert property (calm && cm && o_chan_b_match_flag && fn == 2'h3
        |-> pins != $past(pins)) else $error("no toggle");
    chk_pwm_force: assert property (calm && ctrl_q.chan_b_mode_sel == MODE_PWM && !fn[1]
        |-> pins == {3{(fn[0] ~^ ctrl_q.chan_b_init_level) ^ ctrl_q.chan_b_invert}}) else $error("bad force");
    cover property (calm && cm && o_chan_b_match_flag);
    cover property (o_capture_strobe);
    cover property (calm && ctrl_q.chan_b_mode_sel == MODE_PWM && fn == 2'h2);
endmodule
bind etm_chb etm_chb_properties etm_chb_properties_inst (.i_clock(i_clock), .i_rst(i_rst),
    .i_clk_en(i_clk_en), .i_count_tick(i_count_tick), .i_req(i_req), .i_chan_b_pin_in(i_chan_b_pin_in),
    .o_rdata(o_rdata), .o_chan_b_pin_out(o_chan_b_pin_out), .o_chan_b_pin_oe_n(o_chan_b_pin_oe_n),
    .o_chan_b_match_flag(o_chan_b_match_flag), .o_capture_strobe(o_capture_strobe));

// >>> bench/pin_load.sv
// external signal source and load on the three channel-b pins
`timescale 1ns/100ps
module pin_load (
    input wire logic [2:0] i_out,
    input wire logic [2:0] i_oe_n,
    input wire logic i_level,
    output logic [2:0] o_wire
);
    // the far side drives only where the block has let go of the pin
    assign o_wire = (~i_oe_n & i_out) | (i_oe_n & {3{i_level}});
endmodule

// >>> bench/tb.sv
// self-checking bench for the channel-b timer block
`timescale 1ns/100ps
module tb;
    import etm_chb_pkg::*;
    logic i_clock = 1'b0;
    logic i_rst = 1'b1;
    logic i_clk_en = 1'b1;
    logic i_count_tick = 1'b1;
    reg_req_t i_req = '0;
    logic drv = 1'b0;
    logic [2:0] pw, po, pe;
    logic [7:0] rdata;
    logic flag, cap;
    int err_count = 0;
    int check_count = 0;
    etm_chb etm_chb_inst (.i_clock(i_clock), .i_rst(i_rst), .i_clk_en(i_clk_en), .i_count_tick(i_count_tick),
        .i_req(i_req), .i_chan_b_pin_in(pw), .o_rdata(rdata), .o_chan_b_pin_out(po),
        .o_chan_b_pin_oe_n(pe), .o_chan_b_match_flag(flag), .o_capture_strobe(cap));
    pin_load pin_load_inst (.i_out(po), .i_oe_n(pe), .i_level(drv), .o_wire(pw));
    initial begin
        forever #2 i_clock = ~i_clock;
    end
    // ----------------------------------------
    // bus and checking helpers
    // ----------------------------------------
    task automatic check(input logic [7:0] s, input logic [7:0] e);
        check_count++;
        if (s !== e) begin
            err_count++;
            $display("BAD %0t seen %h want %h", $time, s, e);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge i_clock);
        i_req <= '{a, d, 1'b1, 1'b0};
        @(posedge i_clock);
        i_req.wr <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] a, input logic [7:0] e);
        @(posedge i_clock);
        i_req <= '{a, 8'h00, 1'b0, 1'b1};
        @(posedge i_clock);
        i_req.rd <= 1'b0;
        @(negedge i_clock);
        check(rdata, e);
    endtask
    // timer off around every mode change, both channels in the same mode
    task automatic cfg(input logic [7:0] c);
        wr(4'h8, 8'h00);
        wr(4'h0, c);
        wr(4'h1, c);
        wr(4'h8, 8'h01);
        repeat (2) @(negedge i_clock);
    endtask
    task automatic wait_flag;
        int n;
        n = 0;
        while (flag !== 1'b1 && n < 60) begin
            @(negedge i_clock);
            n++;
        end
    endtask
    task automatic strobes(output int n);
        n = 0;
        repeat (8) begin
            @(negedge i_clock);
            n += (cap === 1'b1);
        end
    endtask
    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    task automatic t_regs;
        // the on bit stays clear here so the counter reads back as zero
        for (int a = 2; a < 10; a++) begin
            if (a != 8) begin
                wr(a[3:0], 8'hFF);
            end
        end
        for (int a = 0; a < 10; a++) begin
            rd(a[3:0], (a == 4 || a == 6) ? 8'hFF : (a == 5 || a == 7) ? 8'h03 : 8'h00);
        end
    endtask
    task automatic t_compare;
        logic lvl;
        wr(4'h4, 8'h00);
        wr(4'h5, 8'h00);
        wr(4'h6, 8'h0C);
        wr(4'h7, 8'h00);
        for (int i = 0; i < 16; i++) begin
            lvl = (i[1:0] == 2'h0) ? i[2] : (i[1:0] == 2'h3) ? !i[2] : i[1];
            cfg({2'b00, i[1:0], i[2], i[3], 2'b00});
            check({5'h0, po}, {5'h0, {3{i[2] ^ i[3]}}});
            wait_flag;
            check({7'h0, flag}, 8'h01);
            check({5'h0, po}, {5'h0, {3{lvl ^ i[3]}}});
        end
    endtask
    task automatic t_count;
        @(posedge i_clock);
        i_count_tick <= 1'b0;
        wr(4'h8, 8'h00);
        wr(4'h8, 8'h01);
        rd(4'h2, 8'h00);
        wr(4'h2, 8'hFF);
        rd(4'h2, 8'h00);
        @(posedge i_clock);
        i_count_tick <= 1'b1;
        repeat (5) @(posedge i_clock);
        i_clk_en <= 1'b0;
        repeat (3) @(posedge i_clock);
        i_clk_en <= 1'b1;
        i_count_tick <= 1'b0;
        rd(4'h2, 8'h05);
        @(posedge i_clock);
        i_count_tick <= 1'b1;
    endtask
    task automatic t_pwm;
        int hi;
        for (int i = 0; i < 8; i++) begin
            cfg({2'b10, 1'b0, i[0], i[1], i[2], 2'b00});
            check({5'h0, po}, {5'h0, {3{(i[0] ~^ i[1]) ^ i[2]}}});
            check({5'h0, pe}, 8'h00);
        end
        wr(4'h4, 8'h10);
        for (int al = 0; al < 4; al++) begin
            cfg({2'b10, 2'b10, 1'b1, 1'b0, al[1:0]});
            hi = 0;
            repeat (64) begin
                @(negedge i_clock);
                hi += (po[0] === 1'b1);
            end
            check({7'h0, hi > 0 && hi < 64}, 8'h01);
        end
    endtask
    task automatic t_capture;
        int r, f;
        for (int i = 0; i < 4; i++) begin
            cfg({2'b01, i[1:0], 4'h0});
            check({5'h0, pe}, 8'h07);
            @(posedge i_clock);
            drv <= 1'b1;
            strobes(r);
            @(posedge i_clock);
            drv <= 1'b0;
            strobes(f);
            check({6'h0, r > 0, f > 0}, {6'h0, i == 0 || i == 2, i == 1 || i == 2});
        end
    endtask
    task automatic t_timer;
        cfg({2'b11, 2'b00, 1'b1, 1'b1, 2'b00});
        check({5'h0, pe}, 8'h07);
        wait_flag;
        check({7'h0, flag}, 8'h01);
    endtask
    task automatic tally_and_finish;
        $display("checks %0d errors %0d", check_count, err_count);
        if (err_count == 0 && check_count > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    // the tests need about a thousand cycles; fifty times that means a hang
    initial begin
        #200000;
        err_count++;
        tally_and_finish;
    end
    initial begin
        repeat (5) @(posedge i_clock);
        i_rst <= 1'b0;
        t_regs;
        t_compare;
        t_count;
        t_pwm;
        t_capture;
        t_timer;
        tally_and_finish;
    end
endmodule
